// *** hfd_consts.vh ***
/*
 Constants for the haptic frame decoder: register offsets, frame field
 positions, reset values and timebase figures.
 Assumes a 25 MHz system clock.
*/
`ifndef HFD_CONSTS_VH
`define HFD_CONSTS_VH

`define HFD_CLK_HZ 25000000
`define HFD_CLK_KHZ 25000

`define HFD_OFF_CTRL 12'h000
`define HFD_OFF_STATUS 12'h004
`define HFD_OFF_IRQ_STAT 12'h008
`define HFD_OFF_IRQ_MASK 12'h00C
`define HFD_OFF_FRAME0 12'h010
`define HFD_OFF_FRAME1 12'h014
`define HFD_OFF_BASE 12'h018

`define HFD_CTRL_SHORT_TICK 0
`define HFD_CTRL_START 1
`define HFD_IRQ_FAULT 0
`define HFD_IRQ_DONE 1

`define HFD_BIT_TYPE 7
`define HFD_GAIN_HI 6
`define HFD_GAIN_LO 5
`define HFD_TB_HI 4
`define HFD_TB_LO 3
`define HFD_IDX_HI 2
`define HFD_IDX_LO 0
`define HFD_REP_HI 6
`define HFD_REP_LO 3
`define HFD_BIT_FCMD 2
`define HFD_BIT_F8 1
`define HFD_BIT_IDXH 0

`define HFD_IRQ_MASK_RST 2'h0
`define HFD_DRIVE_FREQUENCY_CODE_MIN_HZ 25
`define HFD_DRIVE_FREQUENCY_CODE_STEP_HZ 2
`define HFD_SILENT_TICKS 4'h2

`define HFD_TB_1360_US 1360
`define HFD_TB_5440_US 5440
`define HFD_TB_21760_US 21760
`define HFD_TB_43520_US 43520
`define HFD_TB_87040_US 87040

`endif

// *** hfd_tick_len.v ***
/*
 Maps a two-bit timebase code and the short-tick scale to a tick length
 in clock cycles.
 Assumes the constants header and a 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hfd_consts.vh"
module hfd_tick_len #(
  parameter CW = 22
) (
  input wire [1:0] tb_code,
  input wire short_tick,
  output reg [CW-1:0] cycles
);
  localparam [CW-1:0] C1360 = (`HFD_TB_1360_US * (`HFD_CLK_KHZ / 1000));
  localparam [CW-1:0] C5440 = (`HFD_TB_5440_US * (`HFD_CLK_KHZ / 1000));
  localparam [CW-1:0] C21760 = (`HFD_TB_21760_US * (`HFD_CLK_KHZ / 1000));
  localparam [CW-1:0] C43520 = (`HFD_TB_43520_US * (`HFD_CLK_KHZ / 1000));
  localparam [CW-1:0] C87040 = (`HFD_TB_87040_US * (`HFD_CLK_KHZ / 1000));
  always @* begin
    if (!short_tick) begin
      case (tb_code)
        2'h0: cycles = C5440;
        2'h1: cycles = C21760;
        2'h2: cycles = C43520;
        default: cycles = C87040;
      endcase
    end else begin
      case (tb_code)
        2'h0: cycles = C1360;
        2'h1: cycles = C5440;
        2'h2: cycles = C21760;
        default: cycles = C43520;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** hfd_frame_decoder.v ***
/*
 Haptic frame decoder: fetches frame bytes from waveform memory over a
 simple read port, decodes one frame and presents its playback fields.
 Assumes memory data arrives in the same cycle as MEM_RD, and AHB-Lite access.
*/
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hfd_consts.vh"
module hfd_frame_decoder #(
  parameter AW = 7,
  parameter CW = 22
) (
  input wire SYS_CLK,
  input wire RESET,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  output reg MEM_RD,
  output reg [AW-1:0] MEM_ADDR,
  input wire [7:0] MEM_DATA,
  output reg FRAME_VALID,
  output reg [3:0] SNIPPET_INDEX,
  output reg [4:0] ATTEN_DB,
  output reg [CW-1:0] TICK_CYCLES,
  output reg [4:0] PLAY_COUNT,
  output reg SILENT,
  output reg [3:0] SILENT_TICKS,
  output reg DRIVE_FREQUENCY_CODE_VALID,
  output reg [10:0] DRIVE_DRIVE_FREQUENCY_CODE_HZ,
  output reg IRQ
);
  // One-hot decoder states.
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_B1 = 6'h02;
  localparam [5:0] S_B2 = 6'h04;
  localparam [5:0] S_B3 = 6'h08;
  localparam [5:0] S_OUT = 6'h10;
  localparam [5:0] S_WAIT = 6'h20;

  reg [5:0] state_reg;
  reg short_tick_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_mask_reg;
  reg [AW-1:0] base_reg;
  reg [AW-1:0] ptr_reg;
  reg [7:0] b1_reg;
  reg [7:0] b2_reg;
  reg has_b2_reg;
  reg [2:0] length_reg;
  reg start_pulse;
  reg fault_ev;
  reg done_ev;
  reg dp_pend_reg;
  reg dp_write_reg;
  reg [11:0] dp_addr_reg;
  wire [CW-1:0] tick_w;
  wire [11:0] off_w;
  wire word_w;
  reg [8:0] fcode;
  reg [10:0] fhz;

  assign off_w = HADDR[11:0];
  // Only whole-word transfers reach the registers; others are ignored.
  assign word_w = (HSIZE == 3'h2);

  hfd_tick_len #(.CW(CW)) u_tick (
    .tb_code(b1_reg[`HFD_TB_HI:`HFD_TB_LO]),
    .short_tick(short_tick_reg),
    .cycles(tick_w)
  );

  // Bus slave: zero wait states, always OKAY.
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      dp_pend_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 12'h000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (HREADY) begin
        dp_pend_reg <= HSEL & HTRANS[1] & word_w;
        dp_write_reg <= HWRITE;
        dp_addr_reg <= {off_w[11:2], 2'b00};
      end
    end
  end

  // Start acts while the data phase of a control write stands.
  always @* begin
    start_pulse = 1'b0;
    if (dp_pend_reg && dp_write_reg &&
        dp_addr_reg == `HFD_OFF_CTRL) begin
      start_pulse = HWDATA[`HFD_CTRL_START];
    end
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      short_tick_reg <= 1'b0;
      irq_mask_reg <= `HFD_IRQ_MASK_RST;
      irq_stat_reg <= 2'h0;
      base_reg <= {AW{1'b0}};
      HRDATA <= 32'h00000000;
    end else begin
      if (dp_pend_reg && dp_write_reg) begin
        if (dp_addr_reg == `HFD_OFF_CTRL) begin
          short_tick_reg <= HWDATA[`HFD_CTRL_SHORT_TICK];
        end else if (dp_addr_reg == `HFD_OFF_IRQ_MASK) begin
          irq_mask_reg <= HWDATA[1:0];
        end else if (dp_addr_reg == `HFD_OFF_BASE) begin
          base_reg <= HWDATA[AW-1:0];
        end
      end
      // Set wins over a simultaneous write-one clear.
      if (dp_pend_reg && dp_write_reg &&
          dp_addr_reg == `HFD_OFF_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~HWDATA[1:0]) |
                        {done_ev, fault_ev};
      end else begin
        irq_stat_reg <= irq_stat_reg | {done_ev, fault_ev};
      end
      // Read data is captured in the address phase and stands one cycle.
      HRDATA <= 32'h00000000;
      if (HREADY && HSEL && HTRANS[1] && !HWRITE && word_w) begin
        if ({off_w[11:2], 2'b00} == `HFD_OFF_CTRL) begin
          HRDATA <= {31'h00000000, short_tick_reg};
        end else if ({off_w[11:2], 2'b00} == `HFD_OFF_STATUS) begin
          HRDATA <= {21'h000000, length_reg, 2'h0, state_reg};
        end else if ({off_w[11:2], 2'b00} == `HFD_OFF_IRQ_STAT) begin
          HRDATA <= {30'h00000000, irq_stat_reg};
        end else if ({off_w[11:2], 2'b00} == `HFD_OFF_IRQ_MASK) begin
          HRDATA <= {30'h00000000, irq_mask_reg};
        end else if ({off_w[11:2], 2'b00} == `HFD_OFF_FRAME0) begin
          HRDATA <= {11'h000, PLAY_COUNT, 3'h0, ATTEN_DB, 2'h0,
                     SILENT, FRAME_VALID, SNIPPET_INDEX};
        end else if ({off_w[11:2], 2'b00} == `HFD_OFF_FRAME1) begin
          HRDATA <= {4'h0, DRIVE_FREQUENCY_CODE_VALID, DRIVE_DRIVE_FREQUENCY_CODE_HZ, 16'h0000};
        end else if ({off_w[11:2], 2'b00} == `HFD_OFF_BASE) begin
          HRDATA <= {{(32-AW){1'b0}}, base_reg};
        end
      end
    end
  end

  // Level interrupt, one cycle behind the status and mask bits.
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Frequency: code times 2 Hz, clamped to a 25 Hz floor.
  always @* begin
    fcode = {b2_reg[`HFD_BIT_F8], MEM_DATA};
    fhz = {1'b0, fcode, 1'b0};
    if (fhz < `HFD_DRIVE_FREQUENCY_CODE_MIN_HZ) begin
      fhz = 11'h019;
    end
  end

  // Memory data for a read issued in one state is sampled in the next, except the first byte: read in S_IDLE, it passes S_WAIT and is sampled in S_B1.
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      state_reg <= S_IDLE;
      ptr_reg <= {AW{1'b0}};
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      has_b2_reg <= 1'b0;
      length_reg <= 3'h0;
      MEM_RD <= 1'b0;
      MEM_ADDR <= {AW{1'b0}};
      fault_ev <= 1'b0;
      done_ev <= 1'b0;
      FRAME_VALID <= 1'b0;
      SNIPPET_INDEX <= 4'h0;
      ATTEN_DB <= 5'h00;
      TICK_CYCLES <= {CW{1'b0}};
      PLAY_COUNT <= 5'h01;
      SILENT <= 1'b0;
      SILENT_TICKS <= 4'h0;
      DRIVE_FREQUENCY_CODE_VALID <= 1'b0;
      DRIVE_DRIVE_FREQUENCY_CODE_HZ <= 11'd0;
    end else begin
      MEM_RD <= 1'b0;
      fault_ev <= 1'b0;
      done_ev <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_pulse) begin
            MEM_RD <= 1'b1;
            MEM_ADDR <= base_reg;
            ptr_reg <= base_reg + {{(AW-1){1'b0}}, 1'b1};
            FRAME_VALID <= 1'b0;
            DRIVE_FREQUENCY_CODE_VALID <= 1'b0;
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          state_reg <= S_B1;
        end
        S_B1: begin
          b1_reg <= MEM_DATA;
          if (MEM_DATA[`HFD_BIT_TYPE]) begin
            // A malformed first byte ends the frame; nothing is presented.
            fault_ev <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            length_reg <= 3'h1;
            MEM_RD <= 1'b1;
            MEM_ADDR <= ptr_reg;
            state_reg <= S_B2;
          end
        end
        S_B2: begin
          // Look-ahead byte only joins the frame when its type flag is 1.
          if (MEM_DATA[`HFD_BIT_TYPE]) begin
            b2_reg <= MEM_DATA;
            has_b2_reg <= 1'b1;
            length_reg <= 3'h2;
            if (MEM_DATA[`HFD_BIT_FCMD]) begin
              MEM_RD <= 1'b1;
              MEM_ADDR <= ptr_reg + {{(AW-1){1'b0}}, 1'b1};
              state_reg <= S_B3;
            end else begin
              state_reg <= S_OUT;
            end
          end else begin
            b2_reg <= 8'h00;
            has_b2_reg <= 1'b0;
            state_reg <= S_OUT;
          end
        end
        S_B3: begin
          // The third byte is the low eight bits of the frequency code.
          length_reg <= 3'h3;
          DRIVE_FREQUENCY_CODE_VALID <= 1'b1;
          DRIVE_DRIVE_FREQUENCY_CODE_HZ <= fhz;
          state_reg <= S_OUT;
        end
        S_OUT: begin
          // field extraction; index 0 is built-in, 1..15 stored.
          SNIPPET_INDEX <= {b2_reg[`HFD_BIT_IDXH] & has_b2_reg,
                            b1_reg[`HFD_IDX_HI:`HFD_IDX_LO]};
          // Attenuation is reported in whole dB.
          case (b1_reg[`HFD_GAIN_HI:`HFD_GAIN_LO])
            2'h0: ATTEN_DB <= 5'h00;
            2'h1: ATTEN_DB <= 5'h06;
            2'h2: ATTEN_DB <= 5'h0C;
            default: ATTEN_DB <= 5'h12;
          endcase
          TICK_CYCLES <= tick_w;
          PLAY_COUNT <= {1'b0, b2_reg[`HFD_REP_HI:`HFD_REP_LO]} + 5'h01;
          if ({b2_reg[`HFD_BIT_IDXH] & has_b2_reg,
               b1_reg[`HFD_IDX_HI:`HFD_IDX_LO]} == 4'h0) begin
            SILENT <= 1'b1;
            SILENT_TICKS <= `HFD_SILENT_TICKS;
          end else begin
            SILENT <= 1'b0;
            SILENT_TICKS <= 4'h0;
          end
          FRAME_VALID <= 1'b1;
          done_ev <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          // An illegal state code falls back to idle.
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** hfd_mem_model.sv ***
/*
 Waveform memory model: a byte array read by address.
 Assumes the decoder holds MEM_ADDR steady while a byte is fetched.
*/
`timescale 1ns/1ps
`default_nettype none
module hfd_mem_model (
  input wire logic clk,
  input wire logic [6:0] addr,
  output logic [7:0] data
);
  logic [7:0] mem [0:127];
  // The read is combinational: the decoder samples the second and third
  // bytes at the edge after the one that moved the address, so a registered
  // read would hand it the previous byte.
  assign data = mem[addr];
endmodule
`default_nettype wire

// *** hfd_frame_decoder_asserts.sv ***
/*
 Checker for the frame decoder outputs.
 Assumes it is bound to the decoder top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module hfd_frame_decoder_asserts #(
  parameter AW = 7,
  parameter CW = 22
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic MEM_RD,
  input wire logic FRAME_VALID,
  input wire logic [3:0] SNIPPET_INDEX,
  input wire logic [4:0] ATTEN_DB,
  input wire logic [CW-1:0] TICK_CYCLES,
  input wire logic [4:0] PLAY_COUNT,
  input wire logic SILENT,
  input wire logic [3:0] SILENT_TICKS,
  input wire logic DRIVE_FREQUENCY_CODE_VALID,
  input wire logic [10:0] DRIVE_DRIVE_FREQUENCY_CODE_HZ,
  input wire logic IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  a_silent_index: assert property (
    FRAME_VALID && SNIPPET_INDEX == 4'h0 |-> SILENT)
    else $error("index zero frame not silent");
  a_silent_ticks: assert property (
    FRAME_VALID && SILENT |-> SILENT_TICKS == 4'h2)
    else $error("silent snippet length wrong");
  a_stored_audible: assert property (
    FRAME_VALID && SNIPPET_INDEX != 4'h0 |-> !SILENT)
    else $error("stored snippet flagged silent");
  a_read_pulse: assert property (
    MEM_RD ##1 MEM_RD |=> !MEM_RD)
    else $error("memory read burst longer than two cycles");
  a_atten_step: assert property (
    FRAME_VALID |-> ATTEN_DB inside {5'h0, 5'h6, 5'hC, 5'h12})
    else $error("attenuation off the gain steps");
  a_tick_table: assert property (
    FRAME_VALID |-> TICK_CYCLES inside {22'h84D0, 22'h21340,
      22'h84D00, 22'h109A00, 22'h213400})
    else $error("tick length not in table");
  a_play_range: assert property (
    FRAME_VALID |-> PLAY_COUNT inside {[5'h01:5'h10]})
    else $error("play count out of range");
  a_drive_frequency_code_floor: assert property (
    DRIVE_FREQUENCY_CODE_VALID |-> DRIVE_DRIVE_FREQUENCY_CODE_HZ inside {[11'h019:11'h3FE]})
    else $error("drive frequency out of range");
  c_silent: cover property (FRAME_VALID && SILENT);
  c_drive_frequency_code_clamp: cover property (DRIVE_FREQUENCY_CODE_VALID && DRIVE_DRIVE_FREQUENCY_CODE_HZ == 11'h019);
  c_irq: cover property ($rose(IRQ));
endmodule
bind hfd_frame_decoder hfd_frame_decoder_asserts #(.AW(AW), .CW(CW)) chk_u (
  .SYS_CLK, .RESET, .MEM_RD, .FRAME_VALID, .SNIPPET_INDEX, .ATTEN_DB,
  .TICK_CYCLES, .PLAY_COUNT, .SILENT, .SILENT_TICKS, .DRIVE_FREQUENCY_CODE_VALID,
  .DRIVE_DRIVE_FREQUENCY_CODE_HZ, .IRQ
);
`default_nettype wire

// *** hfd_frame_decoder_tb.sv ***
/*
 Self-checking bench for the frame decoder: AHB-Lite tasks and frames.
 Assumes the memory model answers in the same cycle as the address.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hfd_consts.vh"
module hfd_frame_decoder_tb;
  logic SYS_CLK = 0, RESET = 1, HSEL = 0, HWRITE = 0, HREADY;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, r;
  logic [1:0] HTRANS = 0;
  logic [2:0] HSIZE = 3'h2;
  logic HREADYOUT, HRESP, MEM_RD, FRAME_VALID, SILENT, DRIVE_FREQUENCY_CODE_VALID, IRQ;
  logic [6:0] MEM_ADDR;
  logic [7:0] MEM_DATA;
  logic [3:0] SNIPPET_INDEX, SILENT_TICKS;
  logic [4:0] ATTEN_DB, PLAY_COUNT;
  logic [21:0] TICK_CYCLES;
  logic [10:0] DRIVE_DRIVE_FREQUENCY_CODE_HZ;
  int mismatches = 0, n_tests = 0;
  assign HREADY = HREADYOUT;
  hfd_frame_decoder dut_u (.SYS_CLK, .RESET, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP,
    .MEM_RD, .MEM_ADDR, .MEM_DATA, .FRAME_VALID, .SNIPPET_INDEX,
    .ATTEN_DB, .TICK_CYCLES, .PLAY_COUNT, .SILENT, .SILENT_TICKS,
    .DRIVE_FREQUENCY_CODE_VALID, .DRIVE_DRIVE_FREQUENCY_CODE_HZ, .IRQ);
  hfd_mem_model mem_u (.clk(SYS_CLK), .addr(MEM_ADDR), .data(MEM_DATA));
  initial begin
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wt;
    int i;
    i = 0;
    do begin
      @(posedge SYS_CLK);
      i++;
    end while (HREADY !== 1'b1 && i < 50);
    if (i >= 50) begin
      mismatches++;
      final_report;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {20'h0, a};
    HWRITE <= w;
    wt;
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wt;
    r = HRDATA;
  endtask
  task automatic go(input logic [7:0] b0, b1, b2, input logic sc);
    int i;
    mem_u.mem[7'h20] = b0;
    mem_u.mem[7'h21] = b1;
    mem_u.mem[7'h22] = b2;
    bus(1'b1, `HFD_OFF_CTRL, {30'h0, 1'b1, sc});
    repeat (2) @(posedge SYS_CLK);
    i = 0;
    do begin
      bus(1'b0, `HFD_OFF_STATUS, 32'h0);
      i++;
    end while (r[5:0] !== 6'h01 && i < 60);
    chk(r[5:0], 6'h01);
  endtask
  task automatic run(input logic [7:0] b0, b1, b2, input logic sc,
      input logic [31:0] idx, att, tick, play, fq);
    go(b0, b1, b2, sc);
    chk(FRAME_VALID, 1);
    chk(SNIPPET_INDEX, idx);
    chk(SILENT, idx == 32'h0);
    if (idx == 32'h0) chk(SILENT_TICKS, 32'h2);
    chk(ATTEN_DB, att);
    chk(TICK_CYCLES, tick);
    chk(PLAY_COUNT, play);
    if (fq != 32'h0) chk({DRIVE_FREQUENCY_CODE_VALID, DRIVE_DRIVE_FREQUENCY_CODE_HZ}, fq | 32'h800);
    else chk(DRIVE_FREQUENCY_CODE_VALID, 0);
    bus(1'b0, `HFD_OFF_FRAME0, 32'h0);
    chk(r, {11'h000, play[4:0], 3'h0, att[4:0], 2'h0, idx == 32'h0, 1'b1,
      idx[3:0]});
    $display("frame %h done", b0);
  endtask
  initial begin
    repeat (8) @(posedge SYS_CLK);
    RESET <= 1'b0;
    @(posedge SYS_CLK);
    bus(1'b0, `HFD_OFF_IRQ_MASK, 32'h0);
    chk(r, `HFD_IRQ_MASK_RST);
    bus(1'b0, 12'h040, 32'h0);
    chk(r, 32'h0);
    bus(1'b1, `HFD_OFF_BASE, 32'h20);
    run(8'h00, 8'h00, 8'h00, 0, 0, 0, 32'h21340, 1, 0);
    run(8'h7F, 8'hFF, 8'hFF, 0, 15, 18, 32'h213400, 16, 32'h3FE);
    run(8'h29, 8'h84, 8'h05, 0, 1, 6, 32'h84D00, 1, 32'h19);
    run(8'h13, 8'h00, 8'h00, 0, 3, 0, 32'h109A00, 1, 0);
    run(8'h50, 8'hB8, 8'h00, 1, 0, 12, 32'h84D00, 8, 0);
    run(8'h00, 8'h00, 8'h00, 1, 0, 0, 32'h84D0, 1, 0);
    run(8'h08, 8'h00, 8'h00, 1, 0, 0, 32'h21340, 1, 0);
    chk(IRQ, 0);
    bus(1'b1, `HFD_OFF_IRQ_MASK, 32'h1);
    go(8'h80, 8'h00, 8'h00, 0);
    bus(1'b0, `HFD_OFF_IRQ_STAT, 32'h0);
    chk(r[0], 1);
    chk(IRQ, 1);
    bus(1'b1, `HFD_OFF_IRQ_STAT, 32'h3);
    repeat (3) @(posedge SYS_CLK);
    chk(IRQ, 0);
    $display("fault test done");
    final_report;
  end
endmodule
`default_nettype wire
